/* File: design/au_calc.sv */
`timescale 1ns/1ps
// arithmetic core: result is formed at start, released after fixed time
module au_calc (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // start request and operands (byte 0 in the low bits)
    input wire logic i_start,
    input wire au_pkg::au_op_t i_op,
    input wire logic [47:0] i_opr,
    // results
    output logic o_busy,
    output logic o_done,
    output logic [47:0] o_res,
    output logic o_ovf
);
    import au_pkg::*;

    typedef struct packed {
        logic [AU_CNT_W-1:0] cnt;
        logic [47:0] res;
        logic ovf;
    } au_calc_regs_t;

    au_calc_regs_t q;
    au_calc_regs_t next_q;

    // one wide divider shared by both division widths
    always_comb begin
        logic [31:0] dvd;
        logic [15:0] dvs;
        logic [31:0] quo;
        logic [15:0] rem;
        logic [31:0] prod;
        dvd = (i_op == AU_OP_DIV32) ? i_opr[31:0] : {16'h0, i_opr[15:0]};
        dvs = i_opr[47:32];
        quo = '1;
        rem = dvd[15:0];
        prod = i_opr[15:0] * i_opr[47:32];
        next_q = q;
        if (q.cnt != '0) next_q.cnt = q.cnt - 1'b1;
        if (i_start) begin
            if (dvs != 16'h0) begin
                quo = dvd / dvs;
                rem = 16'((dvd % {16'h0, dvs}));
            end
            unique case (i_op)
                AU_OP_DIV32: begin
                    next_q.cnt = AU_LAT_DIV32 - 1'b1;
                    next_q.res = {rem, quo};
                    next_q.ovf = (dvs == 16'h0);
                end
                AU_OP_DIV16: begin
                    next_q.cnt = AU_LAT_DIV16 - 1'b1;
                    next_q.res = {rem, 16'h0, quo[15:0]};
                    next_q.ovf = (dvs == 16'h0);
                end
                AU_OP_MUL: begin
                    next_q.cnt = AU_LAT_MUL - 1'b1;
                    next_q.res = {i_opr[47:32], prod};
                    next_q.ovf = (prod > AU_PROD_MAX);
                end
                default: next_q.cnt = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_busy = (q.cnt != '0);
    assign o_done = (q.cnt == AU_CNT_W'(1));
    assign o_res = q.res;
    assign o_ovf = q.ovf;
endmodule // au_calc

/* File: design/au_pkg.sv */
package au_pkg;
    // register bus geometry, one aligned 32-bit word per register
    localparam int AU_ADDR_W = 8;
    localparam int AU_DATA_W = 32;
    localparam int AU_NUM_BYTES = 6;
    localparam logic [7:0] AU_OFS_BYTE0 = 8'h00;
    localparam logic [7:0] AU_OFS_BYTE5 = 8'h14;
    localparam logic [7:0] AU_OFS_STATUS = 8'h18;
    localparam logic [7:0] AU_OFS_IRQ_STS = 8'h1c;
    localparam logic [7:0] AU_OFS_IRQ_MASK = 8'h20;
    localparam int AU_WORD_SHIFT = 2;

    // operand register indices
    localparam logic [2:0] AU_IDX_0 = 3'h0;
    localparam logic [2:0] AU_IDX_1 = 3'h1;
    localparam logic [2:0] AU_IDX_2 = 3'h2;
    localparam logic [2:0] AU_IDX_3 = 3'h3;
    localparam logic [2:0] AU_IDX_4 = 3'h4;
    localparam logic [2:0] AU_IDX_5 = 3'h5;

    // status and interrupt bit layout
    localparam int AU_ST_ERR_BIT = 7;
    localparam int AU_ST_OVF_BIT = 6;
    localparam int AU_IRQ_W = 2;
    localparam int AU_IRQ_DONE_BIT = 0;
    localparam int AU_IRQ_ERR_BIT = 1;

    // computation time in system clock periods
    localparam int AU_CNT_W = 5;
    localparam logic [4:0] AU_LAT_DIV32 = 5'h11;
    localparam logic [4:0] AU_LAT_DIV16 = 5'h09;
    localparam logic [4:0] AU_LAT_MUL = 5'h0b;

    localparam logic [31:0] AU_PROD_MAX = 32'h0000_ffff;
    localparam logic [1:0] AU_RESP_OKAY = 2'h0;
    localparam logic [1:0] AU_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        AU_OP_DIV32,
        AU_OP_DIV16,
        AU_OP_MUL
    } au_op_t;
endpackage

/* File: design/au_seq.sv */
`timescale 1ns/1ps
// watches operand writes and recognises the three legal write orders
module au_seq (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // operand write strobe
    input wire logic i_wr,
    input wire logic [2:0] i_idx,
    // start request
    output logic o_start,
    output au_pkg::au_op_t o_op
);
    import au_pkg::*;

    typedef enum logic [3:0] {
        SEQ_IDLE, SEQ_B0, SEQ_B01, SEQ_B012, SEQ_B0123, SEQ_B01234,
        SEQ_B014, SEQ_B04, SEQ_B041
    } au_seq_state_t;

    typedef struct packed {
        au_seq_state_t state;
        logic start;
        au_op_t op;
    } au_seq_regs_t;

    au_seq_regs_t q;
    au_seq_regs_t next_q;

    // gaps between writes leave the state alone; only writes move it
    always_comb begin
        next_q = q;
        next_q.start = 1'b0;
        if (i_wr) begin
            next_q.state = SEQ_IDLE; // a broken order waits for idx 0
            if (i_idx == AU_IDX_0) begin
                next_q.state = SEQ_B0; // restart tracking
            end else begin
                unique case (q.state)
                    SEQ_IDLE: next_q.state = SEQ_IDLE;
                    SEQ_B0: begin
                        if (i_idx == AU_IDX_1) next_q.state = SEQ_B01;
                        if (i_idx == AU_IDX_4) next_q.state = SEQ_B04;
                    end
                    SEQ_B01: begin
                        if (i_idx == AU_IDX_2) next_q.state = SEQ_B012;
                        if (i_idx == AU_IDX_4) next_q.state = SEQ_B014;
                    end
                    SEQ_B012:
                        if (i_idx == AU_IDX_3) next_q.state = SEQ_B0123;
                    SEQ_B0123:
                        if (i_idx == AU_IDX_4) next_q.state = SEQ_B01234;
                    SEQ_B01234: if (i_idx == AU_IDX_5) begin
                        next_q.start = 1'b1;
                        next_q.op = AU_OP_DIV32;
                    end
                    SEQ_B014: if (i_idx == AU_IDX_5) begin
                        next_q.start = 1'b1;
                        next_q.op = AU_OP_DIV16;
                    end
                    SEQ_B04:
                        if (i_idx == AU_IDX_1) next_q.state = SEQ_B041;
                    SEQ_B041: if (i_idx == AU_IDX_5) begin
                        next_q.start = 1'b1;
                        next_q.op = AU_OP_MUL;
                    end
                    default: next_q.state = SEQ_IDLE;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{state: SEQ_IDLE, start: 1'b0, op: AU_OP_DIV32};
        end else begin
            q <= next_q;
        end
    end

    assign o_start = q.start;
    assign o_op = q.op;
endmodule // au_seq

/* File: design/au_top.sv */
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - writes 0,1,4,5 with 2,3 untouched select 16/16 division
// - writes 0,4,1,5 with 2,3 untouched select multiplication
// - operation starts only when byte 5 completes a legal order
// - non-operand activity between writes does not break an order
// - latency: 17 cycles div32, 9 cycles div16, 11 cycles multiply
// - operand access while computing sets access error flag, bit 7
// - status read clears access error once computation has finished
// - overflow bit 6: product above ffff or zero divisor
// - overflow flag rewritten at completion of every operation
// - div32 result: quotient in bytes 0..3, remainder in 4..5
// - div16 result: quotient in bytes 0..1, remainder in 4..5
// - multiply result: product bytes 0..3, least significant first
// - reads in any spacing never disturb the stored results
// - status bits 5..0 read zero; both flags zero after reset
module au_top (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [au_pkg::AU_ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [au_pkg::AU_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [au_pkg::AU_ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [au_pkg::AU_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    // interrupt and activity
    output logic o_irq,
    output logic o_busy
);
    import au_pkg::*;

    typedef struct packed {
        logic [AU_NUM_BYTES-1:0][7:0] opr;
        logic err;
        logic ovf;
        logic [AU_IRQ_W-1:0] ists;
        logic [AU_IRQ_W-1:0] imask;
        logic aw_held;
        logic [AU_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [AU_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [AU_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } au_regs_t;

    au_regs_t q;
    au_regs_t next_q;

    // operand engine links
    logic seq_wr;
    logic [2:0] seq_idx;
    logic seq_start;
    au_op_t seq_op;
    logic calc_busy;
    logic calc_done;
    logic [47:0] calc_res;
    logic calc_ovf;
    logic busy;

    // true when the address falls on one of the six operand words
    function automatic logic is_opr(input logic [AU_ADDR_W-1:0] a);
        return (a >= AU_OFS_BYTE0) && (a <= AU_OFS_BYTE5)
            && (a[AU_WORD_SHIFT-1:0] == '0);
    endfunction

    // operand word index of an address
    function automatic logic [2:0] opr_idx(input logic [AU_ADDR_W-1:0] a);
        logic [AU_ADDR_W-1:0] d;
        d = (a - AU_OFS_BYTE0) >> AU_WORD_SHIFT;
        return d[2:0];
    endfunction

    // a mapped address, aligned, of any of the nine registers
    function automatic logic is_mapped(input logic [AU_ADDR_W-1:0] a);
        return is_opr(a) || (a == AU_OFS_STATUS) || (a == AU_OFS_IRQ_STS)
            || (a == AU_OFS_IRQ_MASK);
    endfunction

    // the start pulse already counts as busy, so there is no gap
    // between the last write and the engine taking over
    assign busy = seq_start | calc_busy;

    au_seq u_seq (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr(seq_wr),
        .i_idx(seq_idx),
        .o_start(seq_start),
        .o_op(seq_op)
    );

    au_calc u_calc (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(seq_start),
        .i_op(seq_op),
        .i_opr(q.opr),
        .o_busy(calc_busy),
        .o_done(calc_done),
        .o_res(calc_res),
        .o_ovf(calc_ovf)
    );

    // bus slave, operand store, flags and interrupt bookkeeping
    always_comb begin
        logic [2:0] widx;
        logic [2:0] ridx;
        logic err_set;
        logic [AU_IRQ_W-1:0] w1c;
        widx = opr_idx(q.awaddr);
        ridx = opr_idx(i_araddr);
        err_set = 1'b0;
        w1c = '0;
        next_q = q;
        seq_wr = 1'b0;
        seq_idx = widx;

        // release the answers once taken
        if (q.bvalid && i_bready) next_q.bvalid = 1'b0;
        if (q.rvalid && i_rready) next_q.rvalid = 1'b0;

        // address and data may arrive in either order
        if (i_awvalid && o_awready) begin
            next_q.aw_held = 1'b1;
            next_q.awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            next_q.w_held = 1'b1;
            next_q.wdata = i_wdata;
            next_q.wstrb = i_wstrb;
        end

        // perform a write once both halves are held
        if (q.aw_held && q.w_held && !q.bvalid) begin
            next_q.aw_held = 1'b0;
            next_q.w_held = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = AU_RESP_OKAY;
            if (!is_mapped(q.awaddr)) begin
                next_q.bresp = AU_RESP_SLVERR;
            end else if (is_opr(q.awaddr)) begin
                if (busy) begin
                    err_set = 1'b1; // write is dropped
                end else if (q.wstrb[0]) begin
                    next_q.opr[widx] = q.wdata[7:0];
                    seq_wr = 1'b1;
                end
            end else if (q.awaddr == AU_OFS_IRQ_STS) begin
                w1c = q.wdata[AU_IRQ_W-1:0];
            end else if (q.awaddr == AU_OFS_IRQ_MASK) begin
                next_q.imask = q.wdata[AU_IRQ_W-1:0];
            end
        end

        // read path; reads of results change nothing
        if (i_arvalid && o_arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = AU_RESP_OKAY;
            next_q.rdata = '0;
            if (!is_mapped(i_araddr)) begin
                next_q.rresp = AU_RESP_SLVERR;
            end else if (is_opr(i_araddr)) begin
                next_q.rdata[7:0] = q.opr[ridx];
                if (busy) err_set = 1'b1;
            end else if (i_araddr == AU_OFS_STATUS) begin
                next_q.rdata[AU_ST_ERR_BIT] = q.err; // low bits stay 0
                next_q.rdata[AU_ST_OVF_BIT] = q.ovf;
                if (q.err && !busy) next_q.err = 1'b0;
            end else if (i_araddr == AU_OFS_IRQ_STS) begin
                next_q.rdata[AU_IRQ_W-1:0] = q.ists;
            end else begin
                next_q.rdata[AU_IRQ_W-1:0] = q.imask;
            end
        end

        // error can only be raised while busy and cleared while idle,
        // so the two never meet in one cycle
        if (err_set) next_q.err = 1'b1;

        // completion lands the results; writes are locked out here
        if (calc_done) begin
            next_q.opr = calc_res;
            next_q.ovf = calc_ovf;
        end

        // sticky events: a new event beats a same-cycle clear
        next_q.ists = q.ists & ~w1c;
        if (calc_done) next_q.ists[AU_IRQ_DONE_BIT] = 1'b1;
        if (err_set) next_q.ists[AU_IRQ_ERR_BIT] = 1'b1;
    end

    // state register; operands come up zero rather than unknown
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0; // both flags zero
        end else begin
            q <= next_q;
        end
    end

    // one write and one read in flight at a time
    assign o_awready = !q.aw_held && !q.bvalid;
    assign o_wready = !q.w_held && !q.bvalid;
    assign o_arready = !q.rvalid;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_irq = |(q.ists & q.imask);
    assign o_busy = busy;
endmodule // au_top

/* File: test/au_monitor.sv */
`timescale 1ns/1ps
// watches the bus answers and the length of each computation
module au_monitor (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // write side
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [au_pkg::AU_ADDR_W-1:0] i_awaddr,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    // read side
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [au_pkg::AU_ADDR_W-1:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [au_pkg::AU_DATA_W-1:0] o_rdata,
    input wire logic [1:0] o_rresp,
    // activity
    input wire logic o_busy
);
    import au_pkg::*;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [4:0] run;

    // mapped words are aligned and end at the mask register
    function automatic logic mapped(input logic [7:0] a);
        return (a <= AU_OFS_IRQ_MASK) && (a[1:0] == 2'h0);
    endfunction

    // addresses kept from the accepting edge, busy cycles counted
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wa <= 8'h00;
            ra <= 8'h00;
            run <= 5'h00;
        end else begin
            if (i_awvalid && o_awready) wa <= i_awaddr;
            if (i_arvalid && o_arready) ra <= i_araddr;
            run <= o_busy ? run + 5'h01 : 5'h00;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_busy_length: assert property ($fell(o_busy) |->
        (run == 5'h11 || run == 5'h09 || run == 5'h0b))
        else $error("computation length is not 17, 9 or 11");
    a_start_on_b5: assert property ($rose(o_busy) |->
        $rose(o_bvalid) && wa == AU_OFS_BYTE5)
        else $error("busy rose without a byte 5 write");
    a_status_pad: assert property (o_rvalid &&
        ra == AU_OFS_STATUS |-> o_rdata[5:0] == 6'h00 &&
        o_rdata[31:8] == 24'h000000)
        else $error("status unused bits not zero");
    a_read_resp: assert property (o_rvalid |-> o_rresp ==
        (mapped(ra) ? AU_RESP_OKAY : AU_RESP_SLVERR))
        else $error("read response code wrong");
    a_write_resp: assert property (o_bvalid |-> o_bresp ==
        (mapped(wa) ? AU_RESP_OKAY : AU_RESP_SLVERR))
        else $error("write response code wrong");
    a_read_blocks: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken during read answer");
    a_bresp_once: assert property (o_bvalid && i_bready
        |=> !o_bvalid && o_awready)
        else $error("write answer repeated");
    a_unmapped_zero: assert property (o_rvalid &&
        !mapped(ra) |-> o_rdata == 32'h00000000)
        else $error("unmapped read data not zero");
endmodule // au_monitor

bind au_top au_monitor u_mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_busy(o_busy));

/* File: test/test_multiply_divide_unit.sv */
`timescale 1ns/1ps
// register level test of the arithmetic unit over axi4-lite
module test_multiply_divide_unit;
    import au_pkg::*;
    logic i_mclk, i_rst_n, awv, wv, arv;
    logic awr, wrr, bv, arr, rv, irq, busy;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0] br, rr;
    int fail_count, checks_done, busy_cycles;

    // responses are always accepted at once
    au_top dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
        .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wrr), .i_wdata(wd),
        .i_wstrb(4'h1), .o_bvalid(bv), .i_bready(1'b1), .o_bresp(br),
        .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
        .i_arprot(3'h0), .o_rvalid(rv), .i_rready(1'b1),
        .o_rdata(rdat), .o_rresp(rr), .o_irq(irq), .o_busy(busy)
    );

    // 100 MHz system clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // busy time seen at the sampling edges
    always @(posedge i_mclk) begin
        if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // a wait that ran out ends the run
    task automatic guard(input bit done);
        if (!done) begin
            fail_count++;
            results;
        end
    endtask

    // handshakes are judged at the falling edge, so no race with the dut
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] resp);
        bit ah, wh, bh;
        int n;
        @(posedge i_mclk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bh = 1'b0;
        for (n = 0; n < 50 && !bh; n++) begin
            @(negedge i_mclk);
            ah = awv && awr;
            wh = wv && wrr;
            bh = bv;
            resp = br;
            @(posedge i_mclk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end
        guard(bh);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] resp);
        bit ah, rh;
        int n;
        @(posedge i_mclk);
        arv <= 1'b1;
        ara <= a;
        rh = 1'b0;
        for (n = 0; n < 50 && !rh; n++) begin
            @(negedge i_mclk);
            ah = arv && arr;
            rh = rv;
            d = rdat;
            resp = rr;
            @(posedge i_mclk);
            if (ah) arv <= 1'b0;
        end
        guard(rh);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({16'h0, d}, {16'h0, e});
    endtask

    // writes operand bytes in the nibble order given, a mask read
    // after the first write; poke 1 reads byte 0 while busy, poke 2
    // writes byte 0 while busy and reads the error bit set in status while still busy
    task automatic run_op(input logic [47:0] v, input logic [23:0] ord,
            input int n, input int lat, input int poke);
        logic [2:0] ix;
        logic [31:0] d;
        logic [1:0] r;
        int k;
        for (k = n - 1; k >= 0; k--) begin
            ix = ord[4*k+:3];
            if (k == 0) busy_cycles = 0;
            wr({3'h0, ix, 2'h0}, {24'h0, v[8*ix+:8]}, r);
            if (k == n - 1) rd(AU_OFS_IRQ_MASK, d, r);
        end
        if (poke == 1) rd(AU_OFS_BYTE0, d, r);
        if (poke == 2) begin
            wr(AU_OFS_BYTE0, 32'h0, r);
            rdc(AU_OFS_STATUS, 32'h80);
        end
        // the bench idles the bus until busy falls, for at most 60 falling edges
        for (k = 0; k < 60 && busy !== 1'b0; k++) @(negedge i_mclk);
        guard(busy === 1'b0);
        chk(48'(busy_cycles), 48'(lat));
    endtask

    // results are read in order byte 0 up to byte 5
    task automatic res_chk(input logic [47:0] e);
        logic [47:0] got;
        logic [31:0] d;
        logic [1:0] r;
        int k;
        for (k = 0; k < 6; k++) begin
            rd(8'(4 * k), d, r);
            got[8*k+:8] = d[7:0];
        end
        chk(got, e);
    endtask

    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        awv = 1'b0;
        wv = 1'b0;
        arv = 1'b0;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h0;
        fail_count = 0;
        checks_done = 0;
        busy_cycles = 0;
        i_rst_n = 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rdc(AU_OFS_STATUS, 32'h0);
        rd(8'h24, d, r);
        chk({14'h0, d, r}, {14'h0, 32'h0, AU_RESP_SLVERR});
        wr(8'h02, 32'h1, r);
        chk({46'h0, r}, {46'h0, AU_RESP_SLVERR});
        // a write dropped while busy leaves the quotient intact
        run_op({16'h1234, 32'h12345678}, 24'h012345, 6, 17, 2);
        rdc(AU_OFS_STATUS, 32'h80);
        rdc(AU_OFS_STATUS, 32'h0);
        res_chk({16'(32'h12345678 % 32'h1234),
            32'h12345678 / 32'h1234});
        chk({47'h0, irq}, 48'h0);
        rdc(AU_OFS_IRQ_STS, 32'h3);
        wr(AU_OFS_IRQ_MASK, 32'h3, r);
        @(negedge i_mclk);
        chk({47'h0, irq}, 48'h1);
        wr(AU_OFS_IRQ_STS, 32'h3, r);
        @(negedge i_mclk);
        chk({47'h0, irq}, 48'h0);
        // zero divisor in the short division
        run_op({16'h0, 16'h0, 16'h1234}, 24'h000145, 4, 9, 0);
        rdc(AU_OFS_STATUS, 32'h40);
        res_chk({16'h1234, 32'h0000ffff});
        // a broken order must not start anything
        run_op(48'h0, 24'h000125, 4, 0, 0);
        wr(AU_OFS_IRQ_STS, 32'h3, r);
        run_op({16'h5678, 16'h0, 16'h1234}, 24'h000415, 4, 11, 1);
        chk({47'h0, irq}, 48'h1);
        rdc(AU_OFS_IRQ_STS, 32'h3);
        rdc(AU_OFS_STATUS, 32'hc0);
        rdc(AU_OFS_STATUS, 32'h40);
        res_chk({16'h5678, 32'h1234 * 32'h5678});
        run_op({16'h0003, 16'h0, 16'h0002}, 24'h000415, 4, 11, 0);
        rdc(AU_OFS_STATUS, 32'h0);
        res_chk({16'h0003, 32'h00000006});
        results;
    end
endmodule // test_multiply_divide_unit
